/* logic/burst_sram_regs.svh */
// Constants for the pipelined burst SRAM port and its controller
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH
`define BSR_ADDR_W      18
`define BSR_DATA_W      32
`define BSR_LANES       4
`define BSR_DEPTH_LOG2  6
`define BSR_PIPE_DEPTH  2
`define BSR_BURST_LEN   4
`endif

/* logic/burst_sram_pkg.sv */
// Types used by the memory end of the pipelined burst SRAM link
package burst_sram_pkg;
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_t;
endpackage

/* logic/burst_sram_if.sv */
// Pin bundle between the burst SRAM and its memory controller
`timescale 1ns/1ns
`include "burst_sram_regs.svh"
interface burst_sram_if;
  logic [`BSR_ADDR_W-1:0] addr;               // Address
  logic                   read_not_write;     // High read, low write
  logic                   advance_not_load;   // High advances burst counter
  logic                   cycle_hold_n;       // High ignores the edge
  logic                   select_low_a_n;     // Active-low select
  logic                   select_low_b_n;     // Second active-low select
  logic                   select_pair_b;      // Active-high select
  logic [`BSR_LANES-1:0]  byte_lane_write_n;  // Active-low byte enables
  logic [`BSR_DATA_W-1:0] dq_ctl_o;           // Controller drive value
  logic                   dq_ctl_oe;          // Controller drives the bus
  logic [`BSR_DATA_W-1:0] dq_mem_o;           // Memory drive value
  logic                   dq_mem_oe;          // Memory drives the bus
  logic [`BSR_DATA_W-1:0] dq;                 // Resolved bus level
  assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
  modport mem (input addr, read_not_write, advance_not_load, cycle_hold_n, select_low_a_n,
               select_low_b_n, select_pair_b, byte_lane_write_n, dq,
               output dq_mem_o, dq_mem_oe);
  modport ctl (output addr, read_not_write, advance_not_load, cycle_hold_n, select_low_a_n,
               select_low_b_n, select_pair_b, byte_lane_write_n, dq_ctl_o, dq_ctl_oe,
               input dq);
endinterface

/* logic/burst_sram_mem.sv */
// Pipelined burst SRAM end: two-stage address/data pipeline and storage
// Notes on behaviour
// - Load read drives data two cycles later
// - Advance after load steps counter, ignores selects
// - Burst read outputs successive beats each cycle
// - New load accepted at fourth beat, no gap
// - Controller drives write data two cycles later
// - Burst write stores successive beats each cycle
// - New write load at fourth beat, no gap
// - Deselect tristates bus two cycles later
// - Select needs all three selects true
// - Hold high freezes registers and outputs
// - Burst direction fixed at initial load
`timescale 1ns/1ns
`include "burst_sram_regs.svh"
module burst_sram_mem #(
  parameter int DEPTH_LOG2 = `BSR_DEPTH_LOG2,
  parameter bit LINEAR     = 1'b1
) (
  input  wire logic  clk_sys_i,   // System clock
  input  wire logic  arst_n_i,    // Async reset, active low
  burst_sram_if.mem  bus          // Pins toward the controller
);
  localparam int AW = `BSR_ADDR_W;
  localparam int DW = `BSR_DATA_W;
  localparam int BW = DW / `BSR_LANES;
  initial
  begin
    if (DEPTH_LOG2 < 2 || DEPTH_LOG2 > AW)
      $error("DEPTH_LOG2 out of range");
  end

  logic [DW-1:0] mem_q [0:(1<<DEPTH_LOG2)-1];

  // Next burst address in the low two bits
  function automatic logic [1:0] burst_next(input logic [1:0] start, input logic [1:0] cur);
    logic [1:0] step;
    step = (cur ^ start) + 2'd1;
    burst_next = LINEAR ? cur + 2'd1 : start ^ step;
  endfunction

  // Stage 0: burst state; stage 1 and 2: pending transfers
  logic [AW-1:0]          base_q, cur_q;
  burst_sram_pkg::op_t    op_q;
  burst_sram_pkg::op_t    s1_op_q, s2_op_q;
  logic [AW-1:0]          s1_addr_q, s2_addr_q;
  logic [`BSR_LANES-1:0]  s1_be_n_q, s2_be_n_q;
  logic [DW-1:0]          rd_q;
  logic                   oe_q;

  // Command decode
  wire run      = ~bus.cycle_hold_n;
  wire selected = ~bus.select_low_a_n & ~bus.select_low_b_n & bus.select_pair_b;
  wire is_load  = run & ~bus.advance_not_load & selected;
  wire is_adv   = run & bus.advance_not_load & (op_q != burst_sram_pkg::OP_NONE);
  wire [AW-1:0] adv_addr = {cur_q[AW-1:2], burst_next(base_q[1:0], cur_q[1:0])};
  // Direction is taken from the pin at load only
  wire burst_sram_pkg::op_t load_op = bus.read_not_write ? burst_sram_pkg::OP_READ
                                                         : burst_sram_pkg::OP_WRITE;
  wire burst_sram_pkg::op_t new_op = is_load ? load_op
                                   : (is_adv ? op_q : burst_sram_pkg::OP_NONE);
  wire [AW-1:0] new_addr = is_load ? bus.addr : adv_addr;
  wire [DEPTH_LOG2-1:0] s2_idx = s2_addr_q[DEPTH_LOG2-1:0];
  wire [DEPTH_LOG2-1:0] s1_idx = s1_addr_q[DEPTH_LOG2-1:0];

  // Burst counter and command pipeline; a held edge changes nothing
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_q <= burst_sram_pkg::OP_NONE;
      base_q <= '0;
      cur_q <= '0;
      s1_op_q <= burst_sram_pkg::OP_NONE;
      s2_op_q <= burst_sram_pkg::OP_NONE;
      s1_addr_q <= '0;
      s2_addr_q <= '0;
      s1_be_n_q <= '1;
      s2_be_n_q <= '1;
    end
    else if (run)
    begin
      if (is_load)
      begin
        base_q <= bus.addr;
        cur_q <= bus.addr;
      end
      else if (is_adv)
        cur_q <= adv_addr;
      if (!bus.advance_not_load)
        op_q <= is_load ? load_op : burst_sram_pkg::OP_NONE;
      s1_op_q <= new_op;
      s1_addr_q <= new_addr;
      s1_be_n_q <= bus.byte_lane_write_n;
      s2_op_q <= s1_op_q;
      s2_addr_q <= s1_addr_q;
      s2_be_n_q <= s1_be_n_q;
    end
  end

  // Read data is fetched in stage 1 and driven from stage 2
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_q <= '0;
      oe_q <= 1'b0;
    end
    else if (run)
    begin
      rd_q <= mem_q[s1_idx];
      oe_q <= (s1_op_q == burst_sram_pkg::OP_READ);
    end
  end

  // Write data taken two cycles after its command, per byte lane
  always_ff @(posedge clk_sys_i)
  begin
    if (run && s2_op_q == burst_sram_pkg::OP_WRITE)
      for (int l = 0; l < `BSR_LANES; l++)
        if (!s2_be_n_q[l])
          mem_q[s2_idx][l*BW +: BW] <= bus.dq[l*BW +: BW];
  end

  // Bus drive straight from the registered read data and output enable
  assign bus.dq_mem_o  = rd_q;
  assign bus.dq_mem_oe = oe_q;
endmodule

/* logic/burst_sram_ctl.sv */
// Memory controller end: issues loads and bursts, times data drive
`timescale 1ns/1ns
`include "burst_sram_regs.svh"
module burst_sram_ctl (
  input  wire logic                    clk_sys_i,  // System clock
  input  wire logic                    arst_n_i,   // Async reset, active low
  input  wire logic                    req_i,      // Command valid
  input  wire logic                    req_rd_i,   // High read, low write
  input  wire logic                    req_burst_i,// High four beats, low one
  input  wire logic [`BSR_ADDR_W-1:0]  req_addr_i, // Start address
  input  wire logic [`BSR_LANES-1:0]   req_be_i,   // Byte enables, active high
  input  wire logic                    hold_i,     // Suspend the memory clock edge
  output logic                         req_rdy_o,  // Command taken this cycle
  output logic                         wr_take_o,  // Write beat consumed now
  input  wire logic [`BSR_DATA_W-1:0]  wr_data_i,  // Write beat data
  output logic                         rd_vld_o,   // Read beat valid
  output logic [`BSR_DATA_W-1:0]       rd_data_o,  // Read beat data
  burst_sram_if.ctl                    bus         // Pins toward the memory
);
  logic [1:0]                beats_q;  // Remaining advances
  logic                      wr_burst_q;
  logic [`BSR_LANES-1:0]     be_n_q;
  logic [`BSR_PIPE_DEPTH-1:0] wr_pipe_q, rd_pipe_q;
  logic [`BSR_DATA_W-1:0]    wd_q;
  logic                      wd_oe_q;

  // Command acceptance: new load only once no burst advances remain (beats_q zero)
  wire busy     = beats_q != 2'd0;
  wire take     = req_i & ~busy & ~hold_i;
  wire adv      = busy & ~hold_i;
  wire beat_rd  = (take & req_rd_i) | (adv & ~wr_burst_q);
  wire beat_wr  = (take & ~req_rd_i) | (adv & wr_burst_q);

  // Pin drive from the command decode
  assign req_rdy_o              = take;
  assign bus.cycle_hold_n       = hold_i;
  assign bus.advance_not_load   = busy;
  assign bus.select_low_a_n     = ~take;
  assign bus.select_low_b_n     = ~take;
  assign bus.select_pair_b      = take;
  assign bus.read_not_write     = take ? req_rd_i : 1'b1;
  assign bus.addr               = take ? req_addr_i : '0;
  assign bus.byte_lane_write_n  = take ? ~req_be_i : be_n_q;
  // Beat data is registered at the next live edge, so ask for it one stage early
  assign wr_take_o              = ~hold_i & wr_pipe_q[0];
  assign bus.dq_ctl_o           = wd_q;
  assign bus.dq_ctl_oe          = wd_oe_q;

  // Burst tracking and two-deep data pipelines
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      beats_q <= 2'd0;
      wr_burst_q <= 1'b0;
      be_n_q <= '1;
      wr_pipe_q <= '0;
      rd_pipe_q <= '0;
      wd_q <= '0;
      wd_oe_q <= 1'b0;
      rd_vld_o <= 1'b0;
      rd_data_o <= '0;
    end
    else if (!hold_i)
    begin
      if (take)
      begin
        beats_q <= req_burst_i ? 2'd3 : 2'd0;
        wr_burst_q <= ~req_rd_i;
        be_n_q <= ~req_be_i;
      end
      else if (adv)
        beats_q <= beats_q - 2'd1;
      wr_pipe_q <= {wr_pipe_q[0], beat_wr};
      rd_pipe_q <= {rd_pipe_q[0], beat_rd};
      wd_q <= wr_data_i;
      wd_oe_q <= wr_pipe_q[0];
      rd_vld_o <= rd_pipe_q[`BSR_PIPE_DEPTH-1];
      rd_data_o <= bus.dq;
    end
    else
      rd_vld_o <= 1'b0;
  end
endmodule

/* tb/burst_sram_monitor.sv */
// Checker for the pins between the memory and controller ends
`timescale 1ns/1ns
`include "burst_sram_regs.svh"
module burst_sram_monitor (
  input wire logic                   clk_sys_i,        // System clock
  input wire logic                   arst_n_i,         // Async reset, active low
  input wire logic                   read_not_write,   // Direction
  input wire logic                   advance_not_load, // Advance burst
  input wire logic                   cycle_hold_n,     // High holds the edge
  input wire logic                   select_low_a_n,   // Select a
  input wire logic                   select_low_b_n,   // Select b
  input wire logic                   select_pair_b,    // Active-high select
  input wire logic [`BSR_DATA_W-1:0] dq_mem_o,         // Memory drive value
  input wire logic                   dq_mem_oe,        // Memory drives
  input wire logic                   dq_ctl_oe         // Controller drives
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Decoded pin states
  wire sel_w = !select_low_a_n && !select_low_b_n && select_pair_b;
  wire act_w = !cycle_hold_n;
  wire adv_w = act_w && advance_not_load;
  sequence s_ld_rd; act_w && !advance_not_load && sel_w && read_not_write; endsequence
  sequence s_ld_wr; act_w && !advance_not_load && sel_w && !read_not_write; endsequence
  sequence s_brd; s_ld_rd ##1 adv_w [*3]; endsequence
  sequence s_bwr; s_ld_wr ##1 adv_w [*3]; endsequence
  property p_rd; s_ld_rd ##1 act_w |=> dq_mem_oe; endproperty
  a_rd: assert property (p_rd) else $error("read data late");
  property p_wr; s_ld_wr ##1 act_w ##1 act_w |-> dq_ctl_oe; endproperty
  a_wr: assert property (p_wr) else $error("write data late");
  property p_brd; s_brd |-> dq_mem_oe [*3]; endproperty
  a_brd: assert property (p_brd) else $error("read burst gap");
  property p_bwr; s_bwr |-> dq_ctl_oe [*3]; endproperty
  a_bwr: assert property (p_bwr) else $error("write burst gap");
  property p_b2b_rd; s_brd ##1 s_ld_rd |-> dq_mem_oe [*3]; endproperty
  a_b2b_rd: assert property (p_b2b_rd) else $error("idle cycle between reads");
  property p_b2b_wr; s_bwr ##1 s_ld_wr |-> dq_ctl_oe [*3]; endproperty
  a_b2b_wr: assert property (p_b2b_wr) else $error("idle cycle between writes");
  property p_desel; act_w && !advance_not_load && !sel_w ##1 act_w |=> !dq_mem_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("bus driven after deselect");
  property p_hold; cycle_hold_n |=> $stable(dq_mem_oe) && $stable(dq_mem_o); endproperty
  a_hold: assert property (p_hold) else $error("output moved on held edge");
  property p_excl; !(dq_mem_oe && dq_ctl_oe); endproperty
  a_excl: assert property (p_excl) else $error("both ends drive the bus");
endmodule

/* tb/tb.sv */
// Testbench joining the controller and memory ends
`timescale 1ns/1ns
`include "burst_sram_regs.svh"
module tb;
  typedef struct packed {logic rd; logic burst; logic [`BSR_ADDR_W-1:0] addr;} row_t;
  logic                   clk_sys_i   = 1'b0;
  logic                   arst_n_i    = 1'b0;
  logic                   req_i       = 1'b0;
  logic                   req_rd_i    = 1'b0;
  logic                   req_burst_i = 1'b0;
  logic [`BSR_ADDR_W-1:0] req_addr_i  = '0;
  logic [`BSR_LANES-1:0]  req_be_i    = 4'hf;
  logic                   hold_i      = 1'b0;
  logic [`BSR_DATA_W-1:0] wr_data_i   = '0;
  logic                   req_rdy_o;
  logic                   wr_take_o;
  logic                   rd_vld_o;
  logic [`BSR_DATA_W-1:0] rd_data_o;
  int                     err_total   = 0;
  int                     compares    = 0;
  logic [`BSR_DATA_W-1:0] wq[$];
  logic [`BSR_DATA_W-1:0] rq[$];
  // Writes and reads with turnarounds; expected data follow from the address
  row_t rows [8] = '{'{1'b0, 1'b0, 18'h0_0010}, '{1'b0, 1'b1, 18'h0_0021},
    '{1'b0, 1'b0, 18'h0_0030}, '{1'b1, 1'b0, 18'h0_0010}, '{1'b0, 1'b1, 18'h0_0004},
    '{1'b1, 1'b1, 18'h0_0021}, '{1'b1, 1'b0, 18'h0_0030}, '{1'b1, 1'b1, 18'h0_0004}};
  burst_sram_if bus_if ();
  burst_sram_mem burst_sram_mem_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(bus_if));
  burst_sram_ctl burst_sram_ctl_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .req_rd_i(req_rd_i), .req_burst_i(req_burst_i), .req_addr_i(req_addr_i),
    .req_be_i(req_be_i), .hold_i(hold_i), .req_rdy_o(req_rdy_o), .wr_take_o(wr_take_o),
    .wr_data_i(wr_data_i), .rd_vld_o(rd_vld_o), .rd_data_o(rd_data_o), .bus(bus_if));
  burst_sram_monitor burst_sram_monitor_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .read_not_write(bus_if.read_not_write), .advance_not_load(bus_if.advance_not_load),
    .cycle_hold_n(bus_if.cycle_hold_n), .select_low_a_n(bus_if.select_low_a_n),
    .select_low_b_n(bus_if.select_low_b_n), .select_pair_b(bus_if.select_pair_b),
    .dq_mem_o(bus_if.dq_mem_o), .dq_mem_oe(bus_if.dq_mem_oe), .dq_ctl_oe(bus_if.dq_ctl_oe));
  always #20 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] pat(input logic [17:0] a);
    return 32'(a) ^ 32'h5a5a_0000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Queues the beats of one command in linear wrap order, then holds it until taken
  task automatic issue(input row_t r);
    logic [17:0] a;
    for (int k = 0; k < (r.burst ? 4 : 1); k++)
    begin
      a = {r.addr[17:2], r.addr[1:0] + 2'(k)};
      if (r.rd) rq.push_back(pat(a));
      else wq.push_back(pat(a));
    end
    req_i <= 1'b1;
    req_rd_i <= r.rd;
    req_burst_i <= r.burst;
    req_addr_i <= r.addr;
    do @(negedge clk_sys_i); while (req_rdy_o !== 1'b1);
    @(posedge clk_sys_i);
  endtask
  // Write beat feed and read beat compare
  always @(posedge clk_sys_i)
  begin
    if (wr_take_o === 1'b1) void'(wq.pop_front());
    wr_data_i <= (wq.size() != 0) ? wq[0] : '0;
    if (rd_vld_o === 1'b1) chk(rd_data_o, rq.pop_front());
  end
  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) issue(rows[i]);
    req_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(32'(rq.size()), 32'h0000_0000);
    chk({31'h0000_0000, bus_if.dq_mem_oe}, 32'h0000_0000);
    chk({29'h0000_0000, bus_if.select_low_a_n, bus_if.select_low_b_n, bus_if.select_pair_b},
        32'h0000_0006);
    @(posedge clk_sys_i);
    issue(rows[3]);
    req_i <= 1'b0;
    hold_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    hold_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk(32'(rq.size()), 32'h0000_0000);
    issue(rows[3]);
    req_i <= 1'b0;
    arst_n_i <= 1'b0;
    @(negedge clk_sys_i);
    chk({30'h0000_0000, rd_vld_o, bus_if.dq_mem_oe}, 32'h0000_0000);
    rq.delete();
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    issue(rows[5]);
    req_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk(32'(rq.size()), 32'h0000_0000);
    stop_test();
  end
endmodule
